/* File: rtl/flyback_ctrl.sv */
// switching control of an off-line flyback: gate timing, power modes, burst refresh,
// short-circuit period stretching and latched shutdowns
// assumes every comparator input is asynchronous and power-on drives RST_B low
//
// How it works
// - gate stays on through blanking, then drops once current passes regulation
// - current over target within 1 us stretches next period to 28 us
// - stretching allowed only while the overpower timer runs
// - stretching also needs sampled output below half the overvoltage level
// - overpower time-out halves while stretching is enabled
// - high power runs at fixed 65 kHz, target follows control
// - peak power raises both frequency and peak-current target
// - medium power switches at 25 kHz
// - low power holds target at 22 % and runs slower than 25 kHz
// - overpower compensation output off at low output power
// - no cycle starts while control level is below minimum, except burst refresh pulses
// - supply dropping below burst threshold while idle gives exactly two pulses
// - 130 kHz only at low mains, capped lower at high mains
// - die overtemperature stops switching and latches until power-off
// - overpower timer runs above 400 mV, 160 ms overload latches off
// - output level sampled 2 us after gate turns off
`timescale 1ns/1ns
`default_nettype none
module flyback_ctrl
   import flyback_pkg::*;
#(
   parameter int OPP_CYC = OPP_CYC_DEF
) (
   input  wire logic       SYS_CLK,
   input  wire logic       RST_B,
   input  wire logic       CURRENT_SENSE_INPUT_OVER_REG,
   input  wire logic       CURRENT_SENSE_INPUT_BELOW_HALF_OVP,
   input  wire logic       SENSE_OVER_OPP,
   input  wire logic       CTRL_ABOVE_MIN,
   input  wire logic       CTRL_GT_1V6,
   input  wire logic       CTRL_GT_1V8,
   input  wire logic       CTRL_GT_2V15,
   input  wire logic       CTRL_GT_3V8,
   input  wire logic       BELOW_BURST_SUPPLY_THRESHOLD,
   input  wire logic       DIE_OVERTEMP,
   input  wire logic       HIGH_MAINS,
   output var  logic       GATE_DRV,
   output var  logic       OPC_EN,
   output var  logic [1:0] IPK_SEL,
   output var  logic       LATCH_OFF,
   output var  logic       OSCP_STRETCH
);

   if (OPP_CYC < 4) begin : g_chk
      $error("OPP_CYC too small");
   end

   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   logic [N_IN-1:0] raw;
   logic [N_IN-1:0] meta_q;
   logic [N_IN-1:0] in_s;

   assign raw = {HIGH_MAINS, DIE_OVERTEMP, BELOW_BURST_SUPPLY_THRESHOLD, CTRL_GT_3V8,
                 CTRL_GT_2V15, CTRL_GT_1V8, CTRL_GT_1V6, CTRL_ABOVE_MIN, SENSE_OVER_OPP,
                 CURRENT_SENSE_INPUT_BELOW_HALF_OVP, CURRENT_SENSE_INPUT_OVER_REG};

   // two flops each; costs 100 ns of current-trip latency
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         meta_q <= '0;
         in_s   <= '0;
      end else begin
         meta_q <= raw;
         in_s   <= meta_q;
      end
   end

   // ****************************************************************
   // mode selection
   // ****************************************************************
   mode_t      mode_q;
   mode_t      mode_d;
   logic [1:0] ipk_d;
   logic       opc_d;

   // entry and exit points differ so the mode does not chatter at a threshold
   always_comb begin
      mode_d = mode_q;
      unique case (mode_q)
         MODE_LOW:  if (in_s[IN_GT_1V8]) mode_d = MODE_MED;
         MODE_MED:  if (in_s[IN_GT_2V15]) mode_d = MODE_HIGH;
                    else if (!in_s[IN_GT_1V6]) mode_d = MODE_LOW;
         MODE_HIGH: if (in_s[IN_GT_3V8]) mode_d = MODE_PEAK;
                    else if (!in_s[IN_GT_1V8]) mode_d = MODE_MED;
         MODE_PEAK: if (!in_s[IN_GT_2V15]) mode_d = MODE_HIGH;
         default:   mode_d = MODE_LOW;
      endcase
      unique case (mode_q)
         MODE_PEAK: ipk_d = IPK_BOOST;
         MODE_LOW:  ipk_d = IPK_LOW;
         default:   ipk_d = IPK_CTRL;
      endcase
      opc_d = (mode_q == MODE_HIGH) || (mode_q == MODE_PEAK);
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         mode_q  <= MODE_LOW;
         IPK_SEL <= IPK_LOW;
         OPC_EN  <= 1'b0;
      end else begin
         mode_q  <= mode_d;
         IPK_SEL <= ipk_d;
         OPC_EN  <= opc_d;
      end
   end

   // ****************************************************************
   // overpower timer
   // ****************************************************************
   logic vlow_q;
   logic oscp_en;
   logic opp_exp;

   assign oscp_en = in_s[IN_OPP_LVL] && vlow_q;

   opp_timer #(
      .LIMIT (OPP_CYC)
   ) u_opp (
      .clk    (SYS_CLK),
      .rst_b  (RST_B),
      .run    (in_s[IN_OPP_LVL]),
      .half   (oscp_en),
      .expire (opp_exp)
   );

   // ****************************************************************
   // switching cycle sequencer
   // ****************************************************************
   state_t     state_q;
   state_t     state_d;
   per_t       cyc_q;
   per_t       cyc_d;
   per_t       per_q;
   per_t       per_d;
   per_t       on_q;
   per_t       on_d;
   per_t       off_q;
   per_t       off_d;
   logic       gate_d;
   logic       str_d;
   logic       vlow_d;
   logic [1:0] burst_q;
   logic [1:0] burst_d;
   logic       supl_q;
   logic       shut_d;
   logic       start;
   logic       want;

   // shutdown is checked last so it overrides any start in the same cycle
   always_comb begin
      state_d = state_q;
      cyc_d   = (cyc_q == '1) ? cyc_q : cyc_q + 1'b1;
      per_d   = per_q;
      on_d    = on_q;
      off_d   = off_q;
      gate_d  = 1'b0;
      str_d   = OSCP_STRETCH;
      vlow_d  = vlow_q;
      burst_d = burst_q;
      start   = 1'b0;
      shut_d  = LATCH_OFF || in_s[IN_OTP] || opp_exp;
      want    = !LATCH_OFF && (in_s[IN_CTRL_MIN] || burst_q != 2'h0);
      // refresh pulses armed on the falling-supply edge, only while idle
      if (state_q == ST_IDLE && !in_s[IN_CTRL_MIN] && in_s[IN_SUP_LOW] && !supl_q
          && burst_q == 2'h0)
         burst_d = BURST_PULSES;
      unique case (state_q)
         ST_IDLE: start = want;
         ST_ON: begin
            gate_d = 1'b1;
            on_d   = on_q + 1'b1;
            if (on_q >= LEB_C && in_s[IN_OVER_REG]) begin
               gate_d  = 1'b0;
               state_d = ST_OFF;
               off_d   = '0;
               if (oscp_en && on_q < EARLY_C)
                  str_d = 1'b1;
            end else if (cyc_q >= per_q - 1'b1) begin
               gate_d  = 1'b0;                                                   // never past the period
               state_d = ST_OFF;
               off_d   = '0;
            end
         end
         ST_OFF: begin
            off_d = (off_q == '1) ? off_q : off_q + 1'b1;
            if (off_q == SAMPLE_C)
               vlow_d = in_s[IN_HALF_OVP];
            if (cyc_q >= per_q - 1'b1) begin
               if (want)
                  start = 1'b1;
               else
                  state_d = ST_IDLE;
            end
         end
      endcase
      if (start) begin
         state_d = ST_ON;
         gate_d  = 1'b1;
         cyc_d   = '0;
         on_d    = '0;
         per_d   = sel_period(mode_q, OSCP_STRETCH, in_s[IN_HMAINS]);
         str_d   = 1'b0;
         if (!in_s[IN_CTRL_MIN])
            burst_d = burst_q - 1'b1;
      end
      if (shut_d) begin
         state_d = ST_IDLE;
         gate_d  = 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_q      <= ST_IDLE;
         cyc_q        <= '0;
         per_q        <= LOW_C;
         on_q         <= '0;
         off_q        <= '0;
         vlow_q       <= 1'b0;
         burst_q      <= 2'h0;
         supl_q       <= 1'b0;
         GATE_DRV     <= 1'b0;
         OSCP_STRETCH <= 1'b0;
         LATCH_OFF    <= 1'b0;
      end else begin
         state_q      <= state_d;
         cyc_q        <= cyc_d;
         per_q        <= per_d;
         on_q         <= on_d;
         off_q        <= off_d;
         vlow_q       <= vlow_d;
         burst_q      <= burst_d;
         supl_q       <= in_s[IN_SUP_LOW];
         GATE_DRV     <= gate_d;
         OSCP_STRETCH <= str_d;
         LATCH_OFF    <= shut_d;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   AST_BLANK_MIN: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      $rose(GATE_DRV) |-> (GATE_DRV || LATCH_OFF)[*7]) else $error("gate shorter than blanking");
   AST_TRIP_OFF: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      state_q == ST_ON && on_q >= LEB_C && in_s[IN_OVER_REG] |=> !GATE_DRV)
      else $error("gate not cut after blanking");
   AST_STRETCH_PER: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      start && !shut_d && OSCP_STRETCH |=> per_q == OSCP_C && !OSCP_STRETCH)
      else $error("stretched period wrong");
   AST_STRETCH_CAUSE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      $rose(OSCP_STRETCH) |-> $past(in_s[IN_OPP_LVL]) && $past(vlow_q) && $past(on_q) < EARLY_C)
      else $error("stretch without enable");
   AST_HIGH_PER: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      start && !shut_d && !OSCP_STRETCH && mode_q == MODE_HIGH |=> per_q == HIGH_C)
      else $error("high power period wrong");
   AST_MED_PER: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      start && !shut_d && !OSCP_STRETCH && mode_q == MODE_MED |=> per_q == MED_C)
      else $error("medium power period wrong");
   AST_HMAINS_CAP: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      start && !shut_d && !OSCP_STRETCH && mode_q == MODE_PEAK |=>
      per_q == ($past(in_s[IN_HMAINS]) ? HMAINS_C : PEAK_C)) else $error("peak period wrong");
   AST_LOW_TGT: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      mode_q == MODE_LOW |=> IPK_SEL == IPK_LOW && !OPC_EN) else $error("low power target wrong");
   AST_PEAK_TGT: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      mode_q == MODE_PEAK |=> IPK_SEL == IPK_BOOST && OPC_EN) else $error("peak target wrong");
   AST_NO_START: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      state_q == ST_IDLE && !in_s[IN_CTRL_MIN] && burst_q == 2'h0 |=> !GATE_DRV)
      else $error("cycle below minimum control");
   AST_BURST_ARM: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      state_q == ST_IDLE && !in_s[IN_CTRL_MIN] && in_s[IN_SUP_LOW] && !supl_q && burst_q == 2'h0
      |=> burst_q == BURST_PULSES) else $error("burst not armed");
   AST_LATCHED: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      LATCH_OFF |=> LATCH_OFF && !GATE_DRV) else $error("latch released");
   AST_OTP_STOP: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      in_s[IN_OTP] |=> LATCH_OFF && !GATE_DRV) else $error("overtemp did not stop");

   COV_STRETCH: cover property (@(posedge SYS_CLK) disable iff (!RST_B) $rose(OSCP_STRETCH));
   COV_BURST: cover property (@(posedge SYS_CLK) disable iff (!RST_B)
      burst_q == BURST_PULSES ##[1:1000] burst_q == 2'h0);
   COV_PEAK: cover property (@(posedge SYS_CLK) disable iff (!RST_B) mode_q == MODE_PEAK && GATE_DRV);
   COV_OPP: cover property (@(posedge SYS_CLK) disable iff (!RST_B) opp_exp);

endmodule : flyback_ctrl
`default_nettype wire

/* File: rtl/flyback_pkg.sv */
// constants, types and helpers shared by the flyback switching controller
// assumes one 20 MHz system clock; all times are converted to cycles here
package flyback_pkg;

   // ****************************************************************
   // clock and conversion helpers
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 50;
   localparam int NS_PER_KHZ    = 1_000_000;   // period in ns = this / f_kHz
   localparam int NS_PER_MS     = 1_000_000;

   // longest times round down, never below one cycle
   function automatic int cyc_floor(input int t_ns);
      return (t_ns / CLK_PERIOD_NS < 1) ? 1 : t_ns / CLK_PERIOD_NS;
   endfunction : cyc_floor

   // least times round up
   function automatic int cyc_ceil(input int t_ns);
      return (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   endfunction : cyc_ceil

   // ****************************************************************
   // timing figures
   // ****************************************************************
   localparam int T_LEB_NS       = 325;      // leading-edge blanking
   localparam int T_EARLY_NS     = 1000;     // early over-current window
   localparam int T_SAMPLE_NS    = 2000;     // output-level sample after gate off
   localparam int T_PEAK_PER_NS  = 7700;     // peak-power period
   localparam int T_OSCP_PER_NS  = 28000;    // stretched period
   localparam int F_HIGH_KHZ     = 65;
   localparam int F_MED_KHZ      = 25;
   localparam int F_LOW_KHZ      = 20;       // low-power rate, below medium
   localparam int F_HMAINS_KHZ   = 100;      // peak-rate cap at high mains
   localparam int T_OPP_MS       = 160;      // overpower time-out
   localparam int OPP_CYC_DEF    = T_OPP_MS * (NS_PER_MS / CLK_PERIOD_NS);

   localparam int PER_W = 11;
   typedef logic [PER_W-1:0] per_t;

   localparam per_t LEB_C    = per_t'(cyc_ceil(T_LEB_NS));
   localparam per_t EARLY_C  = per_t'(cyc_floor(T_EARLY_NS));
   localparam per_t SAMPLE_C = per_t'(cyc_floor(T_SAMPLE_NS));
   localparam per_t PEAK_C   = per_t'(cyc_floor(T_PEAK_PER_NS));
   localparam per_t OSCP_C   = per_t'(cyc_floor(T_OSCP_PER_NS));
   localparam per_t HIGH_C   = per_t'(cyc_floor(NS_PER_KHZ / F_HIGH_KHZ));
   localparam per_t MED_C    = per_t'(cyc_floor(NS_PER_KHZ / F_MED_KHZ));
   localparam per_t LOW_C    = per_t'(cyc_floor(NS_PER_KHZ / F_LOW_KHZ));
   localparam per_t HMAINS_C = per_t'(cyc_floor(NS_PER_KHZ / F_HMAINS_KHZ));

   // ****************************************************************
   // burst refresh and peak-current target codes
   // ****************************************************************
   localparam logic [1:0] BURST_PULSES = 2'h2;
   localparam logic [1:0] IPK_LOW      = 2'h0;   // fixed 22 % of maximum
   localparam logic [1:0] IPK_CTRL     = 2'h1;   // follows the control level
   localparam logic [1:0] IPK_BOOST    = 2'h2;   // raised peak-power target

   // ****************************************************************
   // input vector layout and state encodings
   // ****************************************************************
   localparam int IN_OVER_REG  = 0;
   localparam int IN_HALF_OVP  = 1;
   localparam int IN_OPP_LVL   = 2;
   localparam int IN_CTRL_MIN  = 3;
   localparam int IN_GT_1V6    = 4;
   localparam int IN_GT_1V8    = 5;
   localparam int IN_GT_2V15   = 6;
   localparam int IN_GT_3V8    = 7;
   localparam int IN_SUP_LOW   = 8;
   localparam int IN_OTP       = 9;
   localparam int IN_HMAINS    = 10;
   localparam int N_IN         = 11;

   typedef enum logic [3:0] {
      MODE_LOW  = 4'h1,
      MODE_MED  = 4'h2,
      MODE_HIGH = 4'h4,
      MODE_PEAK = 4'h8
   } mode_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_ON   = 3'h2,
      ST_OFF  = 3'h4
   } state_t;

   // period of the next cycle from mode, stretch request and mains level
   function automatic per_t sel_period(input mode_t m, input logic stretch, input logic hmains);
      if (stretch)
         return OSCP_C;
      unique case (m)
         MODE_PEAK: return hmains ? HMAINS_C : PEAK_C;
         MODE_HIGH: return HIGH_C;
         MODE_MED:  return MED_C;
         default:   return LOW_C;
      endcase
   endfunction : sel_period

endpackage : flyback_pkg

/* File: rtl/opp_timer.sv */
// overpower timer: counts while the overload level stands, at double rate when asked
// assumes run and half are already synchronous to clk
`timescale 1ns/1ns
`default_nettype none
module opp_timer
   import flyback_pkg::*;
#(
   parameter int LIMIT = OPP_CYC_DEF
) (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic run,
   input  wire logic half,
   output var  logic expire
);
   localparam int CW = $clog2(LIMIT + 2);
   localparam logic [CW-1:0] LIM = CW'(LIMIT);

   if (LIMIT < 4) begin : g_chk
      $error("opp_timer LIMIT too small");
   end

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic          exp_d;

   // ****************************************************************
   // counter
   // ****************************************************************
   // step of two halves the time-out without a second limit comparator
   always_comb begin
      cnt_d = '0;
      if (run) begin
         if (cnt_q >= LIM)
            cnt_d = cnt_q;                                 // saturate, no wrap
         else
            cnt_d = cnt_q + (half ? CW'(2) : CW'(1));
      end
      exp_d = run && (cnt_q >= LIM);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q  <= '0;
         expire <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         expire <= exp_d;
      end
   end

   AST_OPP_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
      !run |=> cnt_q == '0) else $error("timer not cleared");
   AST_OPP_HALF: assert property (@(posedge clk) disable iff (!rst_b)
      run && half && cnt_q < LIM - CW'(2) |=> cnt_q == $past(cnt_q) + CW'(2))
      else $error("half time-out step wrong");

endmodule : opp_timer
`default_nettype wire

/* File: tb/flyback_ctrl_bench.sv */
// self-checking bench for the flyback switching controller
// assumes the power stage model closes the current loop; overload time-out shortened
`timescale 1ns/1ns
`default_nettype none
module flyback_ctrl_bench;
   localparam int OPP_SIM = 4000;   // short time-out keeps the run brief
   logic       clk, rst_b, ctrl_min, gt16, gt18, gt215, gt38, opp_lvl, sup_low, hot, hmains, short_out;
   logic       over_reg, below_half, gate, opc_en, latch_off, stretch;
   logic [1:0] ipk;
   logic [7:0] ramp;
   int         err_total = 0, cmp_count = 0, cyc = 0, opp_cyc = 0;

   flyback_ctrl #(.OPP_CYC(OPP_SIM)) flyback_ctrl_inst (
      .SYS_CLK(clk), .RST_B(rst_b), .CURRENT_SENSE_INPUT_OVER_REG(over_reg),
      .CURRENT_SENSE_INPUT_BELOW_HALF_OVP(below_half), .SENSE_OVER_OPP(opp_lvl), .CTRL_ABOVE_MIN(ctrl_min),
      .CTRL_GT_1V6(gt16), .CTRL_GT_1V8(gt18), .CTRL_GT_2V15(gt215), .CTRL_GT_3V8(gt38),
      .BELOW_BURST_SUPPLY_THRESHOLD(sup_low), .DIE_OVERTEMP(hot), .HIGH_MAINS(hmains),
      .GATE_DRV(gate), .OPC_EN(opc_en), .IPK_SEL(ipk), .LATCH_OFF(latch_off), .OSCP_STRETCH(stretch));
   flyback_stage_model flyback_stage_model_inst (
      .clk(clk), .gate(gate), .ramp(ramp), .short_out(short_out), .over_reg(over_reg), .below_half(below_half));

   // ****************************************************************
   // clock, cycle ceiling and overload duration
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // overload counter stops once latched, so it measures the time-out itself
   always @(posedge clk) begin
      cyc <= cyc + 1;
      opp_cyc <= opp_lvl ? ((latch_off !== 1'b1) ? opp_cyc + 1 : opp_cyc) : 0;
      if (cyc == 50000) begin
         err_total++;
         final_report();
      end
   end

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %0d seen %0d", what, exp, seen);
      end
   endtask : check
   task automatic in_range(input string what, input int seen, input int lo, input int hi);
      check(what, seen, (seen >= lo && seen <= hi) ? seen : lo);
   endtask : in_range
   // inputs move on the rising edge, outputs are looked at on the falling one
   task automatic do_reset();
      @(posedge clk);
      rst_b <= 1'b0;
      {ctrl_min, gt16, gt18, gt215, gt38, opp_lvl, sup_low, hot, hmains, short_out} <= 10'h000;
      ramp <= 8'h1e;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
   endtask : do_reset
   // one gate rise to the next: on time and whole period in cycles
   task automatic measure(output int per, output int ton);
      int n;
      n = 0;
      ton = 0;
      while (gate !== 1'b1 && n < 4000) begin
         @(negedge clk);
         n++;
      end
      while (gate === 1'b1 && ton < 2000) begin
         @(negedge clk);
         ton++;
      end
      per = ton;
      while (gate !== 1'b1 && per < 2000) begin
         @(negedge clk);
         per++;
      end
   endtask : measure
   task automatic pulses(input int cycles, output int n);
      logic prev;
      n = 0;
      prev = gate;
      repeat (cycles) begin
         @(negedge clk);
         if (gate === 1'b1 && prev !== 1'b1)
            n++;
         prev = gate;
      end
   endtask : pulses
   task automatic wait_latch();
      for (int i = 0; i < 6000 && latch_off !== 1'b1; i++)
         @(negedge clk);
   endtask : wait_latch
   // second period after a level change is the first one chosen in the new mode
   task automatic step(input logic [4:0] lv, input int per_exp, input logic [1:0] ipk_exp, input logic opc_exp);
      int per, ton;
      @(posedge clk);
      {hmains, gt38, gt215, gt18, gt16} <= lv;
      measure(per, ton);
      measure(per, ton);
      check("period", per, per_exp);
      check("peak target", ipk, ipk_exp);
      check("compensation enable", opc_en, opc_exp);
      in_range("regulated on time", ton, 30, 37);
   endtask : step

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_idle();
      int n;
      do_reset();
      @(negedge clk);
      check("gate after reset", gate, 1'b0);
      check("latch after reset", latch_off, 1'b0);
      check("target after reset", ipk, 2'h0);
      pulses(2500, n);
      check("cycles below minimum", n, 0);
      $display("idle test done");
   endtask : t_idle
   task automatic t_modes();
      do_reset();
      @(posedge clk);
      ctrl_min <= 1'b1;
      step(5'h00, 1000, 2'h0, 1'b0);
      step(5'h03, 800, 2'h1, 1'b0);
      step(5'h07, 307, 2'h1, 1'b1);
      step(5'h0f, 154, 2'h2, 1'b1);
      step(5'h1f, 200, 2'h2, 1'b1);
      step(5'h07, 154, 2'h2, 1'b1);
      step(5'h03, 307, 2'h1, 1'b1);
      step(5'h01, 800, 2'h1, 1'b0);
      step(5'h00, 1000, 2'h0, 1'b0);
      $display("mode test done");
   endtask : t_modes
   task automatic t_stretch();
      int per, ton;
      do_reset();
      @(posedge clk);
      {ctrl_min, gt16, gt18, gt215, gt38, short_out} <= 6'h3f;
      ramp <= 8'h00;
      repeat (4) measure(per, ton);
      check("peak period without overload", per, 154);
      check("blanking on time", ton, 8);
      @(posedge clk);
      opp_lvl <= 1'b1;
      repeat (2) measure(per, ton);
      check("stretched period", per, 560);
      repeat (20) @(negedge clk);
      check("stretch flag", stretch, 1'b1);
      @(posedge clk);
      ramp <= 8'h1e;
      repeat (2) measure(per, ton);
      check("period after stretch", per, 154);
      wait_latch();
      in_range("halved time-out", opp_cyc, OPP_SIM / 2 - 2, OPP_SIM / 2 + 8);
      $display("stretch test done");
   endtask : t_stretch
   task automatic t_opp();
      int per, ton;
      do_reset();
      @(posedge clk);
      {ctrl_min, gt16, gt18, gt215, gt38, opp_lvl} <= 6'h3f;
      ramp <= 8'h00;
      repeat (4) measure(per, ton);
      check("no stretch with output high", per, 154);
      wait_latch();
      in_range("full time-out", opp_cyc, OPP_SIM - 2, OPP_SIM + 8);
      pulses(1000, ton);
      check("gate after overpower latch", ton, 0);
      $display("overpower test done");
   endtask : t_opp
   task automatic t_burst();
      int n;
      do_reset();
      @(posedge clk);
      sup_low <= 1'b1;
      pulses(4000, n);
      check("refresh pulses", n, 2);
      $display("burst test done");
   endtask : t_burst
   task automatic t_otp();
      int n;
      do_reset();
      @(posedge clk);
      ctrl_min <= 1'b1;
      pulses(1200, n);
      check("switching before overtemperature", n, 2);
      @(posedge clk);
      hot <= 1'b1;
      repeat (6) @(posedge clk);
      hot <= 1'b0;
      pulses(2000, n);
      check("gate after overtemperature", n, 0);
      check("overtemperature latch", latch_off, 1'b1);
      $display("overtemperature test done");
   endtask : t_otp

   initial begin
      rst_b = 1'b0;
      {ctrl_min, gt16, gt18, gt215, gt38, opp_lvl, sup_low, hot, hmains, short_out} = 10'h000;
      ramp = 8'h1e;
      t_idle();
      t_modes();
      t_stretch();
      t_opp();
      t_burst();
      t_otp();
      final_report();
   end
endmodule : flyback_ctrl_bench
`default_nettype wire

/* File: tb/flyback_stage_model.sv */
// power stage model: primary current ramp seen on the sense pin and output level
// assumes the gate is sampled on the controller clock; one cycle = 50 ns
`timescale 1ns/1ns
`default_nettype none
module flyback_stage_model (
   input  wire logic       clk,
   input  wire logic       gate,
   input  wire logic [7:0] ramp,
   input  wire logic       short_out,
   output var  logic       over_reg,
   output var  logic       below_half
);
   // ****************************************************************
   // primary current and secondary stroke level
   // ****************************************************************
   logic [7:0] on_cnt_q;
   // on-time counter; the current collapses the moment the switch opens
   always_ff @(posedge clk) begin
      on_cnt_q <= gate ? ((on_cnt_q == 8'hff) ? on_cnt_q : on_cnt_q + 8'h01) : 8'h00;
   end
   // current passes regulation after ramp cycles of on time
   assign over_reg = gate && (on_cnt_q >= ramp);
   // during the primary stroke the pin shows current, not the output, so the level is wrong on purpose
   assign below_half = gate ? ~short_out : short_out;
endmodule : flyback_stage_model
`default_nettype wire
